// >>> include/ssrp_pkg.sv
// Constants, types and helpers shared by the synchronous SRAM pipeline
package ssrp_pkg;

	// ************************************************
	// Geometry
	// ************************************************
	localparam int LANES      = 4;
	localparam int LANE_W     = 9;
	localparam int PAR_BIT    = 8;
	localparam int DQ_W       = LANES * LANE_W;
	localparam int ADDR_W     = 10;
	localparam int DEPTH      = 1 << ADDR_W;
	localparam int BURST_W    = 2;
	localparam int BUF_DEPTH  = 2;

	// ************************************************
	// Reset values
	// ************************************************
	localparam logic [ADDR_W-1:0]  ADDR_RST  = 10'h000;
	localparam logic [BURST_W-1:0] CNT_RST   = 2'h0;
	localparam logic [1:0]         SYNC_RST  = 2'h0;

	typedef enum logic [1:0] {
		SSRP_IDLE,
		SSRP_RD_BURST,
		SSRP_WR_BURST
	} ssrp_burst_t;

	// Low address bits of a burst step
	function automatic logic [BURST_W-1:0] ssrp_burst_lo(
		input logic [BURST_W-1:0] base,
		input logic [BURST_W-1:0] cnt,
		input logic               linear);
		ssrp_burst_lo = linear ? BURST_W'(base + cnt) : (base ^ cnt);
	endfunction

	// Bit mask of the lanes; parity bits only when parity lanes are on
	function automatic logic [DQ_W-1:0] ssrp_lane_mask(
		input logic [LANES-1:0] lanes,
		input logic             parity_on);
		logic [DQ_W-1:0] m;
		m = '0;
		for (int k = 0; k < LANES; k++) begin
			for (int b = 0; b < LANE_W; b++) begin
				m[k*LANE_W+b] = lanes[k] & ((b != PAR_BIT) | parity_on);
			end
		end
		ssrp_lane_mask = m;
	endfunction

endpackage

// >>> hw/ssrp_skid_buf.sv
// Two-entry read data buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module ssrp_skid_buf
	import ssrp_pkg::*;
(
	input  wire logic            i_clk,
	input  wire logic            i_rst_n,
	input  wire logic            i_ce,
	input  wire logic            i_in_valid,
	output logic                 o_in_ready,
	input  wire logic [DQ_W-1:0] i_in_data,
	output logic                 o_out_valid,
	input  wire logic            i_out_ready,
	output logic [DQ_W-1:0]      o_out_data
);
	typedef struct packed {
		logic [BUF_DEPTH-1:0][DQ_W-1:0] d;
		logic                           wp;
		logic                           rp;
		logic [1:0]                     cnt;
	} ssrp_buf_t;

	ssrp_buf_t st_q;
	ssrp_buf_t st_d;
	logic      push;
	logic      pop;

	assign o_in_ready  = (st_q.cnt != 2'(BUF_DEPTH));
	assign o_out_valid = (st_q.cnt != 2'h0);
	assign o_out_data  = st_q.d[st_q.rp];
	assign push        = i_ce & i_in_valid & o_in_ready;
	assign pop         = i_ce & o_out_valid & i_out_ready;

	always_comb begin
		st_d = st_q;
		if (push) begin
			st_d.d[st_q.wp] = i_in_data;
			st_d.wp         = ~st_q.wp;
		end
		if (pop) begin
			st_d.rp = ~st_q.rp;
		end
		st_d.cnt = 2'(st_q.cnt + {1'b0, push} - {1'b0, pop});
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	chk_buf_full_block: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(st_q.cnt == 2'(BUF_DEPTH)) && !pop |=> (st_q.cnt == 2'(BUF_DEPTH)))
		else $error("buffer lost a word while full");

endmodule // ssrp_skid_buf
`default_nettype wire

// >>> hw/ssrp_sram_core.sv
// Synchronous SRAM with pipelined and flow-through read/write pipelines
`timescale 1ns/100ps
`default_nettype none
module ssrp_sram_core
	import ssrp_pkg::*;
(
	input  wire logic               I_CLK,
	input  wire logic               I_ARST_N,
	input  wire logic               I_CKE_N,
	input  wire logic [ADDR_W-1:0]  I_ADDR,
	input  wire logic               I_BURST_STEP,
	input  wire logic               I_WRITE_N,
	input  wire logic [LANES-1:0]   I_BYTE_STROBE_N,
	input  wire logic               I_CHIP_SELECT_ONE_N,
	input  wire logic               I_CHIP_SELECT_TWO,
	input  wire logic               I_CHIP_SELECT_THREE_N,
	input  wire logic               I_OUT_ENABLE_N,
	input  wire logic               I_SLEEP_REQUEST,
	input  wire logic               I_PASS_THROUGH_SELECT_N,
	input  wire logic               I_LINEAR_ORDER_SELECT_N,
	input  wire logic               I_PARITY_LANES_N,
	input  wire logic [DQ_W-1:0]    I_DQ,
	output logic [DQ_W-1:0]         O_DQ,
	output logic [DQ_W-1:0]         O_DQ_OE,
	output logic                    O_SLEEP,
	output logic                    O_BUF_READY
);
	// ************************************************
	// State
	// ************************************************
	typedef struct packed {
		ssrp_burst_t         mode;
		logic [ADDR_W-1:0]   base;
		logic [BURST_W-1:0]  cnt;
		logic                w1_v;
		logic [ADDR_W-1:0]   w1_a;
		logic [LANES-1:0]    w1_be;
		logic                w2_v;
		logic [ADDR_W-1:0]   w2_a;
		logic [LANES-1:0]    w2_be;
		logic                pipe_v;
		logic [DQ_W-1:0]     pipe_d;
	} ssrp_state_t;

	ssrp_state_t         st_q;
	ssrp_state_t         st_d;
	logic [1:0]          rst_sync_q;
	logic                rst_n;
	logic [DQ_W-1:0]     mem [DEPTH];

	logic                ce;
	logic                sel;
	logic                ld;
	logic                bur;
	logic                rd_cmd;
	logic                wr_cmd;
	logic                rd_acc;
	logic                wr_acc;
	logic                flow;
	logic                linear;
	logic                parity_on;
	logic [LANES-1:0]    be;
	logic [BURST_W-1:0]  cnt_nx;
	logic [ADDR_W-1:0]   acc_addr;
	logic                wr_en;
	logic [ADDR_W-1:0]   wr_addr;
	logic [LANES-1:0]    wr_be;
	logic [DQ_W-1:0]     wr_mask;
	logic                buf_vld;
	logic [DQ_W-1:0]     buf_dout;
	logic                drive;
	logic                wr_due;

	// ************************************************
	// Reset release
	// ************************************************
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			rst_sync_q <= SYNC_RST;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ************************************************
	// Command decode
	// ************************************************
	// Sleep also stalls the pipeline so nothing moves while asleep
	assign ce        = ~I_CKE_N & ~I_SLEEP_REQUEST;
	assign sel       = ~I_CHIP_SELECT_ONE_N & I_CHIP_SELECT_TWO
		& ~I_CHIP_SELECT_THREE_N;
	assign flow      = ~I_PASS_THROUGH_SELECT_N;
	assign linear    = ~I_LINEAR_ORDER_SELECT_N;
	assign parity_on = ~I_PARITY_LANES_N;
	assign be        = ~I_BYTE_STROBE_N;
	assign ld        = ce & ~I_BURST_STEP;
	assign bur       = ce & I_BURST_STEP;
	assign rd_cmd    = ld & sel & I_WRITE_N;
	assign wr_cmd    = ld & sel & ~I_WRITE_N;
	// Same launch in both modes; only data latency differs
	assign rd_acc    = rd_cmd | (bur & (st_q.mode == SSRP_RD_BURST));
	assign wr_acc    = wr_cmd | (bur & (st_q.mode == SSRP_WR_BURST));
	// Two-bit counter wraps by itself after the fourth address
	assign cnt_nx    = BURST_W'(st_q.cnt + 2'h1);
	assign acc_addr  = ld ? I_ADDR
		: {st_q.base[ADDR_W-1:BURST_W],
		ssrp_burst_lo(st_q.base[BURST_W-1:0], cnt_nx, linear)};

	// ************************************************
	// Next state
	// ************************************************
	always_comb begin
		st_d = st_q;
		if (ce) begin
			if (ld) begin
				st_d.cnt  = CNT_RST;
				if (!sel) begin
					st_d.mode = SSRP_IDLE;
				end else begin
					st_d.base = I_ADDR;
					st_d.mode = I_WRITE_N ? SSRP_RD_BURST : SSRP_WR_BURST;
				end
			end else begin
				case (st_q.mode)
					SSRP_RD_BURST: st_d.cnt = cnt_nx;
					SSRP_WR_BURST: st_d.cnt = cnt_nx;
					SSRP_IDLE:     st_d.cnt = st_q.cnt;
					default:       st_d.mode = SSRP_IDLE;
				endcase
			end
			// A strobe-less write is a no-op and never enters the pipe
			st_d.w1_v   = wr_acc & (|be);
			st_d.w1_a   = acc_addr;
			st_d.w1_be  = be;
			st_d.w2_v   = st_q.w1_v & ~flow;
			st_d.w2_a   = st_q.w1_a;
			st_d.w2_be  = st_q.w1_be;
			st_d.pipe_v = buf_vld;
			st_d.pipe_d = buf_dout;
		end
	end

	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// ************************************************
	// Memory array
	// ************************************************
	assign wr_en   = ce & (flow ? st_q.w1_v : st_q.w2_v);
	assign wr_addr = flow ? st_q.w1_a : st_q.w2_a;
	assign wr_be   = flow ? st_q.w1_be : st_q.w2_be;
	assign wr_mask = ssrp_lane_mask(wr_be, parity_on);

	// Parity bits of a 32-bit write keep their old value
	always_ff @(posedge I_CLK) begin
		if (wr_en) begin
			mem[wr_addr] <= (mem[wr_addr] & ~wr_mask) | (I_DQ & wr_mask);
		end
	end

	// ************************************************
	// Read data path
	// ************************************************
	ssrp_skid_buf u_buf (
		.i_clk       (I_CLK),
		.i_rst_n     (rst_n),
		.i_ce        (ce),
		.i_in_valid  (rd_acc),
		.o_in_ready  (O_BUF_READY),
		.i_in_data   (mem[acc_addr]),
		.o_out_valid (buf_vld),
		.i_out_ready (~I_SLEEP_REQUEST),
		.o_out_data  (buf_dout)
	);

	// Flow-through shows the buffer head, pipelined the extra stage
	assign O_DQ   = flow ? buf_dout : st_q.pipe_d;
	assign drive  = flow ? buf_vld : st_q.pipe_v;
	assign wr_due = flow ? st_q.w1_v : st_q.w2_v;
	// Frozen state keeps the bus as it was during a clock enable stall; sleep turns the drivers off
	assign O_DQ_OE = (drive & ~wr_due & ~I_OUT_ENABLE_N & ~I_SLEEP_REQUEST)
		? ssrp_lane_mask({LANES{1'b1}}, parity_on) : '0;
	assign O_SLEEP = I_SLEEP_REQUEST;

	// ************************************************
	// Checks
	// ************************************************
	sequence s_rd_pipe;
		rd_acc && !flow ##1 ce && !flow;
	endsequence

	sequence s_wr_pipe;
		wr_acc && (|be) && !flow ##1 ce && !flow ##1 !flow;
	endsequence

	chk_stall_hold: assert property (@(posedge I_CLK) disable iff (!rst_n)
		!ce |=> $stable(st_q))
		else $error("state moved while clock enable was off");

	chk_deselect_idle: assert property (@(posedge I_CLK) disable iff (!rst_n)
		ld && !sel |=> st_q.mode == SSRP_IDLE && !st_q.w1_v)
		else $error("deselect did not idle the device");

	chk_read_launch: assert property (@(posedge I_CLK) disable iff (!rst_n)
		rd_cmd |=> st_q.base == $past(I_ADDR) && st_q.mode == SSRP_RD_BURST)
		else $error("read did not load the address");

	chk_pipe_read: assert property (@(posedge I_CLK) disable iff (!rst_n)
		s_rd_pipe |=> st_q.pipe_v)
		else $error("pipelined read data missing after second edge");

	chk_flow_read: assert property (@(posedge I_CLK) disable iff (!rst_n)
		rd_acc && flow |=> buf_vld)
		else $error("flow-through read data missing after command edge");

	chk_no_strobe: assert property (@(posedge I_CLK) disable iff (!rst_n)
		wr_en |-> (|wr_be))
		else $error("write issued with no byte strobe");

	chk_pipe_write: assert property (@(posedge I_CLK) disable iff (!rst_n)
		s_wr_pipe |-> ce |-> wr_en)
		else $error("pipelined write not done at third edge");

	chk_flow_write: assert property (@(posedge I_CLK) disable iff (!rst_n)
		wr_acc && (|be) && flow ##1 ce && flow |-> wr_en)
		else $error("flow-through write not done at second edge");

	chk_burst_order: assert property (@(posedge I_CLK) disable iff (!rst_n)
		bur && st_q.mode != SSRP_IDLE && linear |->
		acc_addr[BURST_W-1:0] == BURST_W'(st_q.base[BURST_W-1:0] + cnt_nx))
		else $error("linear burst address wrong");

	chk_drivers_off: assert property (@(posedge I_CLK) disable iff (!rst_n)
		I_OUT_ENABLE_N || I_SLEEP_REQUEST || wr_due |-> O_DQ_OE == '0)
		else $error("data drivers on when they must be off");

endmodule // ssrp_sram_core
`default_nettype wire

// >>> test/ssrp_host_model.sv
// Host controller model driving the synchronous SRAM bus
`timescale 1ns/100ps
`default_nettype none
module ssrp_host_model
	import ssrp_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_flow,
	input  wire logic              i_load,
	input  wire logic              i_wr,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [LANES-1:0]  i_sb_n,
	input  wire logic [DQ_W-1:0]   i_wdata,
	output logic                   o_step,
	output logic                   o_write_n,
	output logic [ADDR_W-1:0]      o_addr,
	output logic [LANES-1:0]       o_sb_n,
	output var logic [DQ_W-1:0]    o_dq
);
	int              pc = 0;
	logic [DQ_W-1:0] wdue [int];
	// ****************************************
	// Command pins, changed at falling edges
	// ****************************************
	assign o_step    = !i_load;
	assign o_write_n = !i_wr;
	assign o_addr    = i_addr;
	assign o_sb_n    = i_sb_n;
	always @(posedge i_clk) begin
		if (i_wr) wdue[pc + (i_flow ? 1 : 2)] = i_wdata;
		pc++;
	end
	// Released bus toggles so a stale word never passes as good
	initial o_dq = '0;
	always @(negedge i_clk) begin
		if (wdue.exists(pc)) o_dq <= wdue[pc];
		else o_dq <= ~o_dq;
	end
endmodule // ssrp_host_model
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for the synchronous SRAM pipeline
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import ssrp_pkg::*;
	logic              clk, arst_n, cke_n, cs1_n, cs2, cs3_n, oe_n, sleep, ft_n, lin_n, par_n;
	logic              h_load, h_wr, step, write_n, o_sleep, o_rdy, bwr;
	logic [ADDR_W-1:0] h_addr, p_addr, addr, base, a;
	logic [LANES-1:0]  h_sb_n, p_sb_n;
	logic [DQ_W-1:0]   h_wd, dq_in, o_dq, o_oe, pm;
	logic [1:0]        cnt;
	logic [DQ_W-1:0]   mem [int];
	logic [DQ_W-1:0]   exp_q [int];
	int                n_mismatch = 0;
	int                n_compared = 0;
	int                ec = 0;
	int                dsel = 0;
	int                seed = 32'h79dc;

	ssrp_host_model host (.i_clk(clk), .i_flow(!ft_n), .i_load(h_load), .i_wr(h_wr),
		.i_addr(h_addr), .i_sb_n(h_sb_n), .i_wdata(h_wd), .o_step(step),
		.o_write_n(write_n), .o_addr(p_addr), .o_sb_n(p_sb_n), .o_dq(dq_in));
	ssrp_sram_core dut (.I_CLK(clk), .I_ARST_N(arst_n), .I_CKE_N(cke_n), .I_ADDR(p_addr),
		.I_BURST_STEP(step), .I_WRITE_N(write_n), .I_BYTE_STROBE_N(p_sb_n),
		.I_CHIP_SELECT_ONE_N(cs1_n), .I_CHIP_SELECT_TWO(cs2), .I_CHIP_SELECT_THREE_N(cs3_n),
		.I_OUT_ENABLE_N(oe_n), .I_SLEEP_REQUEST(sleep), .I_PASS_THROUGH_SELECT_N(ft_n),
		.I_LINEAR_ORDER_SELECT_N(lin_n), .I_PARITY_LANES_N(par_n), .I_DQ(dq_in),
		.O_DQ(o_dq), .O_DQ_OE(o_oe), .O_SLEEP(o_sleep), .O_BUF_READY(o_rdy));

	// ****************************************
	// Clock, timeout and reporting
	// ****************************************
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		ec++;
		if (ec > 3000) begin
			n_mismatch++;
			final_report;
		end
	end
	task automatic final_report;
		if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input logic [DQ_W-1:0] seen, input logic [DQ_W-1:0] want);
		n_compared++;
		if (seen !== want) begin
			n_mismatch++;
			$display("mismatch at %0t: saw %h, wanted %h", $time, seen, want);
		end
	endtask
	task automatic do_reset;
		arst_n = 0;
		exp_q.delete();
		repeat (2) @(negedge clk);
		arst_n = 1;
		repeat (3) @(negedge clk);
	endtask

	// ****************************************
	// One bus cycle: 0 idle, 1 read, 2 write, 3 step, 4 deselected read
	// ****************************************
	task automatic op(input int k, input logic [ADDR_W-1:0] ad, input logic [LANES-1:0] s);
		logic [DQ_W-1:0] m;
		logic [DQ_W-1:0] d;
		@(negedge clk);
		if (exp_q.exists(ec)) begin
			check(o_oe, pm);
			check(o_dq & pm, exp_q[ec]);
		end else check(o_oe, '0);
		d = DQ_W'({$random(seed), $random(seed)});
		if (k == 3) cnt++;
		else begin
			base = ad;
			cnt = 0;
			bwr = (k == 2);
		end
		addr = {base[ADDR_W-1:2], lin_n ? base[1:0] ^ cnt : base[1:0] + cnt};
		h_load = (k != 3);
		h_wr = (k == 2) || (k == 3 && bwr);
		// Stepped cycles carry a wrong address, so only the counter can be right
		h_addr = (k == 3) ? ~addr : ad;
		h_sb_n = s;
		h_wd = d;
		cs1_n = (k == 0) || (k == 4 && dsel == 0);
		cs2 = !(k == 4 && dsel == 1);
		cs3_n = (k == 4 && dsel == 2);
		if (h_wr) begin
			m = '0;
			for (int j = 0; j < LANES; j++) if (!s[j]) m[j*LANE_W +: LANE_W] = '1;
			m &= pm;
			mem[addr] = (mem[addr] & ~m) | (d & m);
		end
		if (k == 1 || (k == 3 && !bwr)) exp_q[ec + (ft_n ? 2 : 1)] = mem[addr] & pm;
	endtask

	// ****************************************
	// Main sequence over all four flow-through and linear-order pin settings, parity pin following from them
	// ****************************************
	initial begin
		{arst_n, cke_n, oe_n, sleep, h_load, h_wr, bwr, cs2} = '0;
		{cs1_n, cs3_n, ft_n, lin_n, par_n} = '1;
		{h_addr, h_sb_n, h_wd, base, cnt, a, addr, pm} = '0;
		for (int i = 0; i < 4; i++) begin
			ft_n = !i[0];
			lin_n = i[1];
			par_n = i[0] ^ i[1];
			dsel = i % 3;
			for (int j = 0; j < LANES; j++) pm[j*LANE_W +: LANE_W] = par_n ? 9'h0FF : 9'h1FF;
			do_reset;
			a = ADDR_W'($random(seed));
			op(2, a, 4'h0);
			repeat (3) op(3, a, 4'h0);
			op(2, a, 4'($random(seed)));
			repeat (4) op(3, a, 4'($random(seed)));
			op(3, a, 4'hF);
			repeat (3) op(0, a, 4'hF);
			op(1, a, 4'h0);
			repeat (5) op(3, a, 4'h0);
			op(4, a, 4'h0);
			repeat (3) op(0, a, 4'hF);
		end
		// Clock enable off mid-read: data and drivers must hold
		op(1, a, 4'h0);
		@(negedge clk);
		cke_n = 1;
		repeat (3) begin
			@(negedge clk);
			check(o_oe, pm);
			check(o_dq & pm, mem[a] & pm);
		end
		cke_n = 0;
		exp_q.delete();
		// Drivers stay off with output enable high, even for a read
		oe_n = 1;
		op(1, a, 4'h0);
		exp_q.delete();
		repeat (2) begin
			@(negedge clk);
			check(o_oe, '0);
		end
		oe_n = 0;
		sleep = 1;
		@(negedge clk);
		check({{(DQ_W-1){1'b0}}, o_sleep}, 1);
		check(o_oe, '0);
		final_report;
	end
endmodule // testbench
`default_nettype wire
